// *** design/hot_swap_pkg.sv ***
/*
 Constants shared by the hot swap sequencer: timing, source codes, states.
 Assumes a 200 MHz clock and comparator results already squared to logic levels.
*/
package hot_swap_pkg;
    // Clock period in picoseconds
    localparam int clock_period_ps = 5000;
    // Enable glitch filter time in nanoseconds, and its cycle count (least time, round up)
    localparam int enable_filter_ns = 3000;
    localparam int enable_filter_cycles = (enable_filter_ns * 1000 + clock_period_ps - 1) /
        clock_period_ps;
    localparam int filter_count_width = 10;
    // Synchroniser depth
    localparam int sync_stages = 2;
    // Number of synchronised comparator inputs
    localparam int comparator_count = 6;
    // Timer source one-hot codes: bit0 5uA up, bit1 60uA up, bit2 2uA down, bit3 100uA down
    localparam logic [3:0] timer_up_5ua = 4'h1;
    localparam logic [3:0] timer_up_60ua = 4'h2;
    localparam logic [3:0] timer_down_2ua = 4'h4;
    localparam logic [3:0] timer_down_100ua = 4'h8;
    // Gate source one-hot codes: 25mA down, 2mA down, 12uA up, full enhancement
    localparam logic [3:0] gate_down_25ma = 4'h1;
    localparam logic [3:0] gate_down_2ma = 4'h2;
    localparam logic [3:0] gate_up_12ua = 4'h4;
    localparam logic [3:0] gate_full_on = 4'h8;

    typedef enum logic [6:0] {
        st_reset = 7'h01,
        st_init_up = 7'h02,
        st_init_down = 7'h04,
        st_wait_on = 7'h08,
        st_swap = 7'h10,
        st_on = 7'h20,
        st_fault = 7'h40
    } seq_state_type;
endpackage

// *** design/hot_swap_sequencer.sv ***
/*
 Hot swap sequencer: picks the gate drive and timer current source from
 comparator results. Assumes the analog side turns these selects into currents
 and that the comparators report supply, enable, timer and sense levels.
*/
// Function
// - Gate held off until lockout, init, enable
// - Lockout holds reset, release starts init
// - Initial timing cycle precedes any attempt
// - Enable changes under 3 us ignored
// - Enable low after init pulls gate, resets timer
// - Enable high starts attempt after init
// - Timer floor and trip levels end phases
// - Exactly one timer source active
// - Attempt starts with 12 uA gate pull-up
// - Fault current charges timer at 60 uA
// - Current drops: 100 uA down, gate full
// - Timer trip under fault: 2 mA pull-down
// - Latch-off waits for enable cycled
// - Auto-retry forever with timed cool-down
// - Fast trip pulls gate down immediately
// - Reset period: 25 mA gate, 100 uA timer
// - Init: 5 uA up to trip, 100 uA down
// - Cool-down 2 uA down, floor restarts attempt
`timescale 1ns/1ps
module hot_swap_sequencer
    import hot_swap_pkg::*;
#(
    parameter logic auto_retry = 1'b0,
    parameter logic [filter_count_width-1:0] filter_cycles = filter_count_width'(enable_filter_cycles)
) (
    // Clock, reset, enable
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // Comparator results
    input wire logic supply_lockout_in,
    input wire logic enable_in,
    input wire logic timer_floor_level_in,
    input wire logic timer_trip_level_in,
    input wire logic fault_timing_level_in,
    input wire logic fast_trip_level_in,
    // Drive selects
    output logic [3:0] gate_source_out,
    output logic [3:0] timer_source_out,
    output logic fault_out
);

////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [comparator_count-1:0] sync1;
        logic [comparator_count-1:0] sync2;
        logic enable_filt;
        logic enable_prev;
        logic [filter_count_width-1:0] filter_count;
        logic init_done;
        logic armed;
        logic current_seen;
        seq_state_type state;
        logic [3:0] gate_source;
        logic [3:0] timer_source;
        logic fault;
    } seq_regs_type;

    seq_regs_type cur;
    seq_regs_type next_cur;
    logic [comparator_count-1:0] raw;
    logic lockout;
    logic enable_sync;
    logic floor_hit;
    logic trip_hit;
    logic fault_timing;
    logic fast_trip;
    logic enable_rise;

    assign raw = {fast_trip_level_in, fault_timing_level_in, timer_trip_level_in,
        timer_floor_level_in, enable_in, supply_lockout_in};

    // Only the second stage is looked at
    assign lockout = cur.sync2[0];
    assign enable_sync = cur.sync2[1];
    assign floor_hit = cur.sync2[2];
    assign trip_hit = cur.sync2[3];
    assign fault_timing = cur.sync2[4];
    assign fast_trip = cur.sync2[5];
    assign enable_rise = cur.enable_filt && !cur.enable_prev;

////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_cur = cur;
        next_cur.sync1 = raw;
        next_cur.sync2 = cur.sync1;
        next_cur.enable_prev = cur.enable_filt;
        if (enable_sync == cur.enable_filt) begin
            next_cur.filter_count = '0;
        end else if (cur.filter_count >= filter_cycles - 1'b1) begin
            next_cur.enable_filt = enable_sync;
            next_cur.filter_count = '0;
        end else begin
            next_cur.filter_count = cur.filter_count + 1'b1;
        end
        // A fresh rising edge arms an attempt; clear below beats set
        if (enable_rise) begin
            next_cur.armed = 1'b1;
        end
        // Inrush has to be seen anew on every attempt
        if (cur.state != st_swap && cur.state != st_on) begin
            next_cur.current_seen = 1'b0;
        end
        case (cur.state)
            st_reset: begin
                next_cur.gate_source = gate_down_25ma;
                next_cur.timer_source = timer_down_100ua;
                if (!lockout) begin
                    next_cur.state = st_init_up;
                end
            end
            st_init_up: begin
                next_cur.gate_source = gate_down_25ma;
                next_cur.timer_source = timer_up_5ua;
                if (trip_hit) begin
                    next_cur.state = st_init_down;
                end
            end
            st_init_down: begin
                next_cur.timer_source = timer_down_100ua;
                if (!floor_hit) begin
                    next_cur.init_done = 1'b1;
                    next_cur.state = st_wait_on;
                end
            end
            st_wait_on: begin
                next_cur.gate_source = gate_down_25ma;
                next_cur.timer_source = timer_down_100ua;
                // Start whenever enable is high; init_done is always set here, so no rising edge is needed
                if (cur.enable_filt && (cur.armed || enable_rise || !cur.enable_prev ||
                        cur.init_done)) begin
                    next_cur.state = st_swap;
                    next_cur.armed = 1'b0;
                    next_cur.gate_source = gate_up_12ua;
                    next_cur.fault = 1'b0;
                end
            end
            st_swap, st_on: begin
                if (fault_timing) begin
                    next_cur.timer_source = timer_up_60ua;
                    next_cur.current_seen = 1'b1;
                    if (trip_hit) begin
                        next_cur.state = st_fault;
                        next_cur.gate_source = gate_down_2ma;
                        // Post-fault timer phase starts with the gate pull-down
                        next_cur.timer_source = auto_retry ? timer_down_2ua : timer_down_100ua;
                        next_cur.fault = 1'b1;
                    end
                end else if (cur.current_seen) begin
                    next_cur.timer_source = timer_down_100ua;
                    next_cur.gate_source = gate_full_on;
                    next_cur.state = st_on;
                end else begin
                    // Low sense before any inrush is sync lag, not a drop;
                    // a load that never draws timing current keeps the 12 uA pull-up
                    next_cur.timer_source = timer_down_100ua;
                end
            end
            st_fault: begin
                next_cur.gate_source = gate_down_2ma;
                if (auto_retry) begin
                    next_cur.timer_source = timer_down_2ua;
                    if (!floor_hit) begin
                        next_cur.state = st_swap;
                        next_cur.gate_source = gate_up_12ua;
                        next_cur.fault = 1'b0;
                    end
                end else begin
                    next_cur.timer_source = timer_down_100ua;
                    if (enable_rise) begin
                        next_cur.state = st_swap;
                        next_cur.armed = 1'b0;
                        next_cur.gate_source = gate_up_12ua;
                        next_cur.fault = 1'b0;
                    end
                end
            end
            default: begin
                next_cur.state = st_reset;
            end
        endcase
        if (fast_trip && (cur.state == st_swap || cur.state == st_on)) begin
            next_cur.gate_source = gate_down_2ma;
            next_cur.state = st_fault;
            next_cur.fault = 1'b1;
        end
        if (!cur.enable_filt && cur.init_done) begin
            next_cur.state = st_wait_on;
            next_cur.gate_source = gate_down_25ma;
            next_cur.timer_source = timer_down_100ua;
            next_cur.init_done = 1'b1;
        end
        if (lockout) begin
            next_cur.state = st_reset;
            next_cur.init_done = 1'b0;
            // Lockout is a full reset, so the fault flag goes too
            next_cur.fault = 1'b0;
            next_cur.gate_source = gate_down_25ma;
            next_cur.timer_source = timer_down_100ua;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cur.sync1 <= {comparator_count{1'b1}};
            cur.sync2 <= {comparator_count{1'b1}};
            cur.enable_filt <= 1'b0;
            cur.enable_prev <= 1'b0;
            cur.filter_count <= '0;
            cur.init_done <= 1'b0;
            cur.armed <= 1'b0;
            cur.current_seen <= 1'b0;
            cur.state <= st_reset;
            cur.gate_source <= gate_down_25ma;
            cur.timer_source <= timer_down_100ua;
            cur.fault <= 1'b0;
        end else if (clk_en_in) begin
            cur <= next_cur;
        end
    end

////////////////////////////////////////////////////////////////////////////////

    assign timer_source_out = cur.timer_source;
    assign gate_source_out = cur.gate_source;
    assign fault_out = cur.fault;

endmodule // hot_swap_sequencer

// *** tb/hot_swap_far_side.sv ***
/* Far side model: FET load, sense comparators, timing capacitor in mV.
 Assumes one clock per step of capacitor charge. */
`timescale 1ns/1ps
module hot_swap_far_side
    import hot_swap_pkg::*;
(
    // Clock and drive selects
    input wire logic clock_in,
    input wire logic [3:0] gate_source_in,
    input wire logic [3:0] timer_source_in,
    // Load behaviour
    input wire logic short_in,
    input wire logic [7:0] inrush_in,
    // Comparator results
    output logic timer_floor_level_out,
    output logic timer_trip_level_out,
    output logic fault_timing_level_out,
    output logic fast_trip_level_out
);
    int volts = 0;
    int charge = 0;
    wire logic gate_on = gate_source_in == gate_up_12ua || gate_source_in == gate_full_on;
    // Rates scaled so one uA moves one mV a cycle
    always @(posedge clock_in) begin : step
        int next_volts;
        next_volts = volts + (timer_source_in[0] ? 5 : 0) + (timer_source_in[1] ? 60 : 0)
            - (timer_source_in[2] ? 2 : 0) - (timer_source_in[3] ? 100 : 0);
        // The capacitor cannot be pulled below ground
        volts <= next_volts < 0 ? 0 : next_volts;
        charge <= gate_on ? charge + 1 : 0;
    end
    assign timer_floor_level_out = volts > 200;
    assign timer_trip_level_out = volts >= 1300;
    assign fault_timing_level_out = gate_on && charge < int'(inrush_in);
    assign fast_trip_level_out = gate_on && short_in;
endmodule // hot_swap_far_side

// *** tb/hot_swap_sequencer_sva.sv ***
/* Port checker for the hot swap sequencer.
 Assumes clk_en_in is held high. */
`timescale 1ns/1ps
module hot_swap_sequencer_sva
    import hot_swap_pkg::*;
#(
    parameter logic auto_retry = 1'b0,
    parameter logic [filter_count_width-1:0] filter_cycles = 10'h4
) (
    // Inputs
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic supply_lockout_in,
    input wire logic enable_in,
    input wire logic timer_floor_level_in,
    input wire logic timer_trip_level_in,
    input wire logic fault_timing_level_in,
    input wire logic fast_trip_level_in,
    // Outputs
    input wire logic [3:0] gate_source_out,
    input wire logic [3:0] timer_source_out,
    input wire logic fault_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    wire logic gate_on = gate_source_out == gate_up_12ua || gate_source_out == gate_full_on;
    ////////////////////////////////
    a_reset_drive: assert property (disable iff (1'b0)
        rst_in && clk_en_in |=> gate_source_out == gate_down_25ma
        && timer_source_out == timer_down_100ua && !fault_out) else $error("reset drive");
    a_timer_onehot: assert property ($onehot(timer_source_out)) else $error("timer");
    a_gate_lockout: assert property (gate_on |-> !$past(supply_lockout_in, 4))
        else $error("gate on in lockout");
    a_lockout_hold: assert property (supply_lockout_in [*4] |->
        gate_source_out == gate_down_25ma && timer_source_out == timer_down_100ua)
        else $error("lockout hold");
    a_abort_low: assert property ((!enable_in) [*8] |-> !gate_on) else $error("abort");
    a_fault_gate: assert property ($rose(fault_out) |-> gate_source_out == gate_down_2ma)
        else $error("fault gate");
    a_fault_timer: assert property ($rose(fault_out) && timer_trip_level_in |->
        ##[0:2] timer_source_out == (auto_retry ? timer_down_2ua : timer_down_100ua))
        else $error("fault timer");
    a_attempt_clear: assert property (
        $rose(gate_source_out == gate_up_12ua) |-> !fault_out)
        else $error("fault not cleared");
    a_full_timer: assert property ($rose(gate_source_out == gate_full_on) |->
        timer_source_out == timer_down_100ua) else $error("full on timer");
    a_latch_hold: assert property (
        (!auto_retry && fault_out && enable_in && !supply_lockout_in) [*8] |=> fault_out)
        else $error("latch released");
    a_fast_trip: assert property ((fast_trip_level_in && gate_on) [*3] |=> !gate_on)
        else $error("fast trip");
    c_fault: cover property ($rose(fault_out));
    c_full: cover property ($rose(gate_source_out == gate_full_on));
    c_attempt: cover property ($rose(gate_source_out == gate_up_12ua));
endmodule // hot_swap_sequencer_sva

bind hot_swap_sequencer hot_swap_sequencer_sva #(
    .auto_retry(auto_retry),
    .filter_cycles(filter_cycles)
) u_sva (.*);

// *** tb/tb_hot_swap_sequencer.sv ***
/* Bench: latch-off lane 0 checked by notes, auto-retry lane 1 by counts.
 Assumes the far side model drives the timer, fault timing and fast trip comparator results. */
`timescale 1ns/1ps
module tb_hot_swap_sequencer;
    import hot_swap_pkg::*;
    logic clock_in = 0, rst_in = 1, lockout = 1, enable = 1, short_load = 0;
    logic [7:0] inrush = 8'h0a;
    logic [3:0] gate [2], timer [2], prev, prev_r;
    logic fault [2], floor_l [2], trip_l [2], ftime [2], fast [2];
    logic [8:0] notes [$], exp_note;
    int fails = 0, n_checks = 0, retries = 0, seed = 32'h621f;
    initial forever #2.5 clock_in = ~clock_in;
    for (genvar i = 0; i < 2; i++) begin : lane
        hot_swap_sequencer #(.auto_retry(i == 1), .filter_cycles(10'h3)) u_hot_swap_sequencer (
            .clock_in(clock_in), .rst_in(rst_in), .clk_en_in(1'b1),
            .supply_lockout_in(lockout), .enable_in(enable), .timer_floor_level_in(floor_l[i]),
            .timer_trip_level_in(trip_l[i]), .fault_timing_level_in(ftime[i]),
            .fast_trip_level_in(fast[i]), .gate_source_out(gate[i]),
            .timer_source_out(timer[i]), .fault_out(fault[i]));
        hot_swap_far_side u_hot_swap_far_side (
            .clock_in(clock_in), .gate_source_in(gate[i]), .timer_source_in(timer[i]),
            .short_in(short_load), .inrush_in(inrush), .timer_floor_level_out(floor_l[i]),
            .timer_trip_level_out(trip_l[i]), .fault_timing_level_out(ftime[i]),
            .fast_trip_level_out(fast[i]));
    end
    ////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic note(input logic [3:0] g, input logic [3:0] t, input logic f);
        notes.push_back({g, t, f});
    endtask
    // Timer code 0 in a note means the timer is not compared
    task automatic drain(input string name);
        int k;
        k = 0;
        while (notes.size() != 0 && k < 3000) begin
            cyc(1);
            k++;
        end
        if (notes.size() != 0) begin
            fails++;
            give_verdict();
        end else begin
            cyc(10);
            $display("test %s done", name);
        end
    endtask
    // Every change of the lane 0 gate drive takes the oldest note
    always @(posedge clock_in) begin
        #2;
        if (!rst_in && gate[0] !== prev) begin
            exp_note = notes.size() != 0 ? notes.pop_front() : 9'h0;
            n_checks++;
            if ({gate[0], fault[0]} !== {exp_note[8:5], exp_note[0]}
                || (exp_note[4:1] != 4'h0 && timer[0] !== exp_note[4:1])) begin
                fails++;
                $display("[ERR] t=%0t got %h exp %h", $time, {gate[0], timer[0], fault[0]}, exp_note);
            end
        end
        if (gate[1] == gate_up_12ua && prev_r != gate_up_12ua) retries++;
        prev = gate[0];
        prev_r = gate[1];
    end
    ////////////////////////////////
    initial begin
        cyc(6);
        rst_in = 0;
        lockout = 0;
        note(gate_up_12ua, 4'h0, 1'b0);
        note(gate_full_on, timer_down_100ua, 1'b0);
        drain("start");
        for (int i = 0; i < 6; i++) begin
            enable = 0;
            cyc(1 + {$random(seed)} % 2);
            enable = 1;
            cyc(4);
        end
        drain("glitch");
        enable = 0;
        note(gate_down_25ma, timer_down_100ua, 1'b0);
        drain("abort");
        inrush = 8'hc8;
        enable = 1;
        retries = 0;
        note(gate_up_12ua, 4'h0, 1'b0);
        note(gate_down_2ma, timer_down_100ua, 1'b1);
        drain("timed fault");
        // Each cool-down from the trip level takes about 650 cycles
        cyc(2000);
        n_checks++;
        if (retries < 3) begin
            fails++;
            $display("[ERR] t=%0t got %h exp %h", $time, retries, 3);
        end
        enable = 0;
        inrush = 8'h0a;
        note(gate_down_25ma, timer_down_100ua, 1'b1);
        drain("latch off");
        enable = 1;
        note(gate_up_12ua, 4'h0, 1'b0);
        note(gate_full_on, timer_down_100ua, 1'b0);
        drain("reenable");
        short_load = 1;
        note(gate_down_2ma, 4'h0, 1'b1);
        drain("fast trip");
        short_load = 0;
        lockout = 1;
        note(gate_down_25ma, timer_down_100ua, 1'b0);
        drain("lockout");
        lockout = 0;
        note(gate_up_12ua, 4'h0, 1'b0);
        note(gate_full_on, timer_down_100ua, 1'b0);
        drain("restart");
        give_verdict();
    end
endmodule // tb_hot_swap_sequencer
